/* File: hdl/slcr_regs.sv */
// switch link configuration and status registers behind an axi4-lite slave
`timescale 1ns/1ps
module slcr_regs #(
    parameter int ADDR_W = 12
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic global_debug_event,
    input wire logic global_debug_core,
    input wire slcr_pkg::slcr_link_stat_type [slcr_pkg::LINKS-1:0] ext_stat,
    input wire slcr_pkg::slcr_link_flag_type [slcr_pkg::LINKS-1:0] ext_flag,
    input wire slcr_pkg::slcr_link_stat_type [slcr_pkg::LINKS-1:0] proc_stat,
    output slcr_pkg::slcr_link_ctrl_type [slcr_pkg::LINKS-1:0] link_ctrl,
    output logic [slcr_pkg::LINKS-1:0][1:0] proc_net,
    output slcr_pkg::slcr_static_type [slcr_pkg::LINKS-1:0] static_fwd,
    output logic [1:0] debug_source,
    output logic [slcr_pkg::SPARE_W-1:0] spare_bits
);
    // the link lettering of the static bank assumes exactly eight links
    if (ADDR_W < 11 || slcr_pkg::LINKS != 8) begin : g_bad_param
        $error("slcr_regs: ADDR_W must be at least 11 and LINKS must be 8");
    end

    slcr_pkg::slcr_state_type st_reg;
    slcr_pkg::slcr_state_type st_next;
    logic wr_fire;
    slcr_pkg::slcr_sel_type wr_sel;
    logic [31:0] wr_word;

    function automatic slcr_pkg::slcr_sel_type decode(input logic [7:0] idx, input logic bad);
        slcr_pkg::slcr_sel_type s;
        s = slcr_pkg::SEL_NONE;
        if (!bad) begin
            if (idx == slcr_pkg::IDX_SPARE) begin
                s = slcr_pkg::SEL_SPARE;
            end else if (idx == slcr_pkg::IDX_DEBUG) begin
                s = slcr_pkg::SEL_DEBUG;
            end else if (idx[7:3] == slcr_pkg::IDX_EXT_STAT[7:3]) begin
                s = slcr_pkg::SEL_EXT;
            end else if (idx[7:3] == slcr_pkg::IDX_PROC_STAT[7:3]) begin
                s = slcr_pkg::SEL_PROC;
            end else if (idx[7:3] == slcr_pkg::IDX_CFG[7:3]) begin
                s = slcr_pkg::SEL_CFG;
            end else if (idx[7:3] == slcr_pkg::IDX_STATIC[7:3]) begin
                s = slcr_pkg::SEL_STATIC;
            end
        end
        return s;
    endfunction

    // static bank lists links C,D,A,B,G,H,E,F: swap pairs of pairs
    function automatic logic [2:0] static_link(input logic [2:0] slot);
        return slot ^ slcr_pkg::STATIC_SWAP;
    endfunction

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                          input logic [3:0] strb);
        logic [31:0] m;
        m = old;
        for (int b = 0; b < 4; b++) begin
            if (strb[b]) begin
                m[b*8 +: 8] = d[b*8 +: 8];
            end
        end
        return m;
    endfunction

    // unused bits stay zero; write-only bits always read zero
    function automatic logic [31:0] rd_word(input slcr_pkg::slcr_sel_type s,
                                            input logic [2:0] l);
        logic [31:0] w;
        logic [2:0] k;
        w = 32'h0;
        k = static_link(l);
        case (s)
            slcr_pkg::SEL_SPARE: begin
                w[slcr_pkg::SPARE_W-1:0] = st_reg.spare;
            end
            slcr_pkg::SEL_DEBUG: begin
                w[slcr_pkg::DBG_RSV_BIT] = st_reg.dbg_rsv;
                w[slcr_pkg::DBG_CORE1_BIT:slcr_pkg::DBG_CORE0_BIT] = st_reg.dbg_src;
            end
            slcr_pkg::SEL_EXT: begin
                w[slcr_pkg::STAT_KIND_LSB +: 2] = ext_stat[l].source_target_kind;
                w[slcr_pkg::STAT_DEST_LSB +: 8] = ext_stat[l].dest;
                w[slcr_pkg::STAT_DIR_LSB +: 4] = st_reg.ext[l].dir;
                w[slcr_pkg::STAT_NET_LSB +: 2] = st_reg.ext[l].net;
                w[slcr_pkg::STAT_JUNK_BIT] = ext_stat[l].junk;
                w[slcr_pkg::STAT_DST_BIT] = ext_stat[l].dst_busy;
                w[slcr_pkg::STAT_SRC_BIT] = ext_stat[l].src_busy;
            end
            slcr_pkg::SEL_PROC: begin
                w[slcr_pkg::STAT_KIND_LSB +: 2] = proc_stat[l].source_target_kind;
                w[slcr_pkg::STAT_DEST_LSB +: 8] = proc_stat[l].dest;
                w[slcr_pkg::STAT_NET_LSB +: 2] = st_reg.pnet[l];
                w[slcr_pkg::STAT_JUNK_BIT] = proc_stat[l].junk;
                w[slcr_pkg::STAT_DST_BIT] = proc_stat[l].dst_busy;
                w[slcr_pkg::STAT_SRC_BIT] = proc_stat[l].src_busy;
            end
            slcr_pkg::SEL_CFG: begin
                w[slcr_pkg::CFG_EN_BIT] = st_reg.ext[l].enable;
                w[slcr_pkg::CFG_FIVE_BIT] = st_reg.ext[l].five_wire;
                w[slcr_pkg::CFG_ERR_BIT] = ext_flag[l].rx_error;
                w[slcr_pkg::CFG_GRANT_BIT] = ext_flag[l].credit_granted;
                w[slcr_pkg::CFG_HELD_BIT] = ext_flag[l].credit_held;
                w[slcr_pkg::CFG_SYM_LSB +: slcr_pkg::GAP_W] = st_reg.ext[l].sym_gap;
                w[slcr_pkg::CFG_TOK_LSB +: slcr_pkg::GAP_W] = st_reg.ext[l].tok_gap;
            end
            slcr_pkg::SEL_STATIC: begin
                w[slcr_pkg::ST_EN_BIT] = st_reg.stat[k].enable;
                w[slcr_pkg::ST_PROC_BIT] = st_reg.stat[k].proc;
                w[slcr_pkg::ST_CHAN_LSB +: 5] = st_reg.stat[k].chan;
            end
            default: begin
                w = 32'h0;
            end
        endcase
        return w;
    endfunction

    assign wr_fire = st_reg.aw_have && st_reg.w_have && !st_reg.bvalid;
    assign wr_sel = decode(st_reg.aw_idx, st_reg.aw_bad);
    // a process, not an assign: rd_word reads state that is not among its arguments
    always_comb begin
        wr_word = merge(rd_word(wr_sel, st_reg.aw_idx[2:0]), st_reg.wdata, st_reg.wstrb);
    end

    always_comb begin
        logic [2:0] l;
        slcr_pkg::slcr_sel_type rs;
        l = st_reg.aw_idx[2:0];
        rs = decode(s_axi_araddr[9:2], |s_axi_araddr[ADDR_W-1:10]);
        st_next = st_reg;
        // greeting and receiver reset are single-cycle strobes to the link
        for (int i = 0; i < slcr_pkg::LINKS; i++) begin
            st_next.ext[i].greet = 1'b0;
            st_next.ext[i].rx_reset = 1'b0;
        end
        if (st_reg.awready && s_axi_awvalid) begin
            st_next.aw_have = 1'b1;
            st_next.aw_idx = s_axi_awaddr[9:2];
            st_next.aw_bad = |s_axi_awaddr[ADDR_W-1:10];
        end
        if (st_reg.wready && s_axi_wvalid) begin
            st_next.w_have = 1'b1;
            st_next.wdata = s_axi_wdata;
            st_next.wstrb = s_axi_wstrb;
        end
        if (st_reg.bvalid && s_axi_bready) begin
            st_next.bvalid = 1'b0;
        end
        if (wr_fire) begin
            st_next.aw_have = 1'b0;
            st_next.w_have = 1'b0;
            st_next.bvalid = 1'b1;
            st_next.bresp = slcr_pkg::RESP_OKAY;
            case (wr_sel)
                slcr_pkg::SEL_SPARE: begin
                    st_next.spare = wr_word[slcr_pkg::SPARE_W-1:0];
                end
                slcr_pkg::SEL_DEBUG: begin
                    st_next.dbg_rsv = wr_word[slcr_pkg::DBG_RSV_BIT];
                    st_next.dbg_src = wr_word[slcr_pkg::DBG_CORE1_BIT:slcr_pkg::DBG_CORE0_BIT];
                end
                slcr_pkg::SEL_EXT: begin
                    st_next.ext[l].dir = wr_word[slcr_pkg::STAT_DIR_LSB +: 4];
                    st_next.ext[l].net = wr_word[slcr_pkg::STAT_NET_LSB +: 2];
                end
                slcr_pkg::SEL_PROC: begin
                    st_next.pnet[l] = wr_word[slcr_pkg::STAT_NET_LSB +: 2];
                end
                slcr_pkg::SEL_CFG: begin
                    st_next.ext[l].enable = wr_word[slcr_pkg::CFG_EN_BIT];
                    st_next.ext[l].five_wire = wr_word[slcr_pkg::CFG_FIVE_BIT];
                    st_next.ext[l].greet = wr_word[slcr_pkg::CFG_GREET_BIT];
                    st_next.ext[l].rx_reset = wr_word[slcr_pkg::CFG_RXRST_BIT];
                    st_next.ext[l].sym_gap =
                        wr_word[slcr_pkg::CFG_SYM_LSB +: slcr_pkg::GAP_W];
                    st_next.ext[l].tok_gap =
                        wr_word[slcr_pkg::CFG_TOK_LSB +: slcr_pkg::GAP_W];
                end
                slcr_pkg::SEL_STATIC: begin
                    st_next.stat[static_link(l)].enable = wr_word[slcr_pkg::ST_EN_BIT];
                    st_next.stat[static_link(l)].proc = wr_word[slcr_pkg::ST_PROC_BIT];
                    st_next.stat[static_link(l)].chan = wr_word[slcr_pkg::ST_CHAN_LSB +: 5];
                end
                default: begin
                    st_next.bresp = slcr_pkg::RESP_SLVERR;
                end
            endcase
        end
        // hardware event after the software write: the event wins
        if (global_debug_event) begin
            st_next.dbg_src = global_debug_core ? 2'h2 : 2'h1;
        end
        st_next.awready = !st_next.aw_have && !st_next.bvalid;
        st_next.wready = !st_next.w_have && !st_next.bvalid;
        if (st_reg.rvalid && s_axi_rready) begin
            st_next.rvalid = 1'b0;
        end
        if (st_reg.arready && s_axi_arvalid) begin
            st_next.rvalid = 1'b1;
            st_next.rdata = rd_word(rs, s_axi_araddr[4:2]);
            st_next.rresp = (rs == slcr_pkg::SEL_NONE) ? slcr_pkg::RESP_SLVERR
                                                        : slcr_pkg::RESP_OKAY;
        end
        st_next.arready = !st_next.rvalid;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign s_axi_awready = st_reg.awready;
    assign s_axi_wready = st_reg.wready;
    assign s_axi_bvalid = st_reg.bvalid;
    assign s_axi_bresp = st_reg.bresp;
    assign s_axi_arready = st_reg.arready;
    assign s_axi_rvalid = st_reg.rvalid;
    assign s_axi_rdata = st_reg.rdata;
    assign s_axi_rresp = st_reg.rresp;
    assign link_ctrl = st_reg.ext;
    assign proc_net = st_reg.pnet;
    assign static_fwd = st_reg.stat;
    assign debug_source = st_reg.dbg_src;
    assign spare_bits = st_reg.spare;

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    sequence ar_take(int idx);
        s_axi_arvalid && st_reg.arready && s_axi_araddr[9:2] == idx[7:0]
            && !(|s_axi_araddr[ADDR_W-1:10]);
    endsequence
    sequence cfg_fire;
        wr_fire && wr_sel == slcr_pkg::SEL_CFG;
    endsequence

    a_debug_core_one: assert property (global_debug_event && global_debug_core |=> debug_source == 2'h2) else $error("debug source not core one");
    a_rd_ext_kind: assert property (ar_take(8'h23) ##1 s_axi_rvalid |-> s_axi_rdata[25:24] == $past(ext_stat[3].source_target_kind) && s_axi_rdata[31:26] == 6'h0) else $error("ext status read wrong");
    a_rd_proc_dest: assert property (ar_take(8'h45) |=> s_axi_rdata[23:16] == $past(proc_stat[5].dest) && s_axi_rdata[11:8] == 4'h0) else $error("proc status read wrong");
    a_dir_write: assert property (wr_fire && wr_sel == slcr_pkg::SEL_EXT && st_reg.wstrb[1] |=> link_ctrl[$past(st_reg.aw_idx[2:0])].dir == $past(st_reg.wdata[11:8])) else $error("direction not stored");
    a_greet_pulse: assert property (cfg_fire and (st_reg.wstrb[3] && st_reg.wdata[24]) |=> link_ctrl[$past(st_reg.aw_idx[2:0])].greet ##1 !link_ctrl[$past(st_reg.aw_idx[2:0], 2)].greet) else $error("greeting not one pulse");
    a_gap_write: assert property (cfg_fire and (st_reg.wstrb[0] && st_reg.wstrb[1]) |=> link_ctrl[$past(st_reg.aw_idx[2:0])].tok_gap == $past(st_reg.wdata[10:0])) else $error("token gap not stored");
    a_static_map: assert property (wr_fire && wr_sel == slcr_pkg::SEL_STATIC && st_reg.aw_idx == 8'ha0 && st_reg.wstrb[3] |=> static_fwd[2].enable == $past(st_reg.wdata[31])) else $error("static slot zero not link c");
    a_spare_read: assert property (ar_take(8'h11) |=> s_axi_rdata[31:2] == 30'h0 && s_axi_rdata[1:0] == $past(spare_bits)) else $error("spare register read wrong");
    a_write_resp: assert property (wr_fire |=> s_axi_bvalid && !s_axi_awready && !s_axi_wready) else $error("write response missing");
endmodule

/* File: hdl/slcr_pkg.sv */
// constants, register map and carrier types for the switch link config registers
package slcr_pkg;
    localparam int LINKS = 8;
    localparam int GAP_W = 11;
    localparam int IDX_W = 8;
    // printed offsets are word indices; byte address = 4 * index
    localparam logic [7:0] IDX_SPARE = 8'h11;
    localparam logic [7:0] IDX_DEBUG = 8'h1f;
    localparam logic [7:0] IDX_EXT_STAT = 8'h20;
    localparam logic [7:0] IDX_PROC_STAT = 8'h40;
    localparam logic [7:0] IDX_CFG = 8'h80;
    localparam logic [7:0] IDX_STATIC = 8'ha0;
    localparam logic [2:0] STATIC_SWAP = 3'h2;
    localparam int SPARE_W = 2;
    localparam int DBG_CORE0_BIT = 0;
    localparam int DBG_CORE1_BIT = 1;
    localparam int DBG_RSV_BIT = 4;
    localparam int STAT_SRC_BIT = 0;
    localparam int STAT_DST_BIT = 1;
    localparam int STAT_JUNK_BIT = 2;
    localparam int STAT_NET_LSB = 4;
    localparam int STAT_DIR_LSB = 8;
    localparam int STAT_DEST_LSB = 16;
    localparam int STAT_KIND_LSB = 24;
    localparam int CFG_TOK_LSB = 0;
    localparam int CFG_SYM_LSB = 11;
    localparam int CFG_RXRST_BIT = 23;
    localparam int CFG_GREET_BIT = 24;
    localparam int CFG_HELD_BIT = 25;
    localparam int CFG_GRANT_BIT = 26;
    localparam int CFG_ERR_BIT = 27;
    localparam int CFG_FIVE_BIT = 30;
    localparam int CFG_EN_BIT = 31;
    localparam int ST_CHAN_LSB = 0;
    localparam int ST_PROC_BIT = 8;
    localparam int ST_EN_BIT = 31;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    localparam logic [1:0] KIND_SWITCH_LINK = 2'h0;
    localparam logic [1:0] KIND_PROCESSOR_LINK = 2'h1;
    localparam logic [1:0] KIND_SWITCH_CONTROL = 2'h2;

    typedef enum logic [2:0] {
        SEL_NONE, SEL_SPARE, SEL_DEBUG, SEL_EXT, SEL_PROC, SEL_CFG, SEL_STATIC
    } slcr_sel_type;

    typedef struct packed {
        logic [1:0] source_target_kind;
        logic [7:0] dest;
        logic junk;
        logic dst_busy;
        logic src_busy;
    } slcr_link_stat_type;

    typedef struct packed {
        logic rx_error;
        logic credit_granted;
        logic credit_held;
    } slcr_link_flag_type;

    typedef struct packed {
        logic enable;
        logic five_wire;
        logic [3:0] dir;
        logic [1:0] net;
        logic [GAP_W-1:0] sym_gap;
        logic [GAP_W-1:0] tok_gap;
        logic greet;
        logic rx_reset;
    } slcr_link_ctrl_type;

    typedef struct packed {
        logic enable;
        logic proc;
        logic [4:0] chan;
    } slcr_static_type;

    typedef struct packed {
        logic aw_have;
        logic w_have;
        logic [IDX_W-1:0] aw_idx;
        logic aw_bad;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic [SPARE_W-1:0] spare;
        logic dbg_rsv;
        logic [1:0] dbg_src;
        slcr_link_ctrl_type [LINKS-1:0] ext;
        logic [LINKS-1:0][1:0] pnet;
        slcr_static_type [LINKS-1:0] stat;
    } slcr_state_type;
endpackage

/* File: dv/slcr_link_model.sv */
// far-end link model: status, credit and error levels seen by the registers
`timescale 1ns/1ps
module slcr_link_model (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic load,
    input wire slcr_pkg::slcr_link_ctrl_type [slcr_pkg::LINKS-1:0] link_ctrl,
    output slcr_pkg::slcr_link_stat_type [slcr_pkg::LINKS-1:0] ext_stat,
    output slcr_pkg::slcr_link_flag_type [slcr_pkg::LINKS-1:0] ext_flag,
    output slcr_pkg::slcr_link_stat_type [slcr_pkg::LINKS-1:0] proc_stat
);
    integer seed = 13;
    logic [31:0] r;
    // levels only move on load or on a pulse, so reads see stable values
    always @(posedge aclk) begin
        if (!aresetn) begin
            ext_stat <= '0;
            ext_flag <= '0;
            proc_stat <= '0;
        end else begin
            for (int i = 0; i < slcr_pkg::LINKS; i++) begin
                if (load) begin
                    r = $random(seed);
                    ext_stat[i] <= r[12:0];
                    proc_stat[i] <= r[28:16];
                    ext_flag[i] <= r[31:29];
                end
                if (link_ctrl[i].greet) ext_flag[i].credit_held <= 1'b0;
                if (link_ctrl[i].rx_reset) ext_flag[i].rx_error <= 1'b0;
            end
        end
    end
endmodule

/* File: dv/slcr_regs_bench.sv */
// self-checking bench for the switch link config registers
`timescale 1ns/1ps
module slcr_regs_bench;
    logic aclk = 1'b0;
    logic rstn = 1'b0;
    logic [11:0] awaddr = 12'h0;
    logic [11:0] araddr = 12'h0;
    logic [31:0] wdata = 32'h0;
    logic [3:0] wstrb = 4'hf;
    logic awvalid = 1'b0;
    logic wvalid = 1'b0;
    logic bready = 1'b0;
    logic arvalid = 1'b0;
    logic rready = 1'b0;
    logic load = 1'b0;
    logic dbg_ev = 1'b0;
    logic dbg_core = 1'b0;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp, dbg_src, spare;
    logic [31:0] rdata, r;
    slcr_pkg::slcr_link_stat_type [7:0] ext_stat, proc_stat;
    slcr_pkg::slcr_link_flag_type [7:0] ext_flag;
    slcr_pkg::slcr_link_ctrl_type [7:0] link_ctrl;
    slcr_pkg::slcr_static_type [7:0] static_fwd;
    logic [7:0][1:0] proc_net;
    logic [31:0] rq[$];
    logic [1:0] rr[$];
    logic [1:0] bq[$];
    int n_errors = 0;
    int n_tests = 0;
    int greet_n[8];
    int rxrst_n[8];
    int g, x;
    integer seed;

    always #5 aclk = ~aclk;

    slcr_regs dut (.aclk(aclk), .aresetn(rstn), .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready), .global_debug_event(dbg_ev),
        .global_debug_core(dbg_core), .ext_stat(ext_stat), .ext_flag(ext_flag),
        .proc_stat(proc_stat), .link_ctrl(link_ctrl), .proc_net(proc_net),
        .static_fwd(static_fwd), .debug_source(dbg_src), .spare_bits(spare));

    slcr_link_model far (.aclk(aclk), .aresetn(rstn), .load(load), .link_ctrl(link_ctrl),
        .ext_stat(ext_stat), .ext_flag(ext_flag), .proc_stat(proc_stat));

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_errors++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic report_and_stop();
        if (n_errors == 0 && n_tests > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] e);
        int t;
        logic aw_left;
        logic w_left;
        t = 0;
        aw_left = 1'b1;
        w_left = 1'b1;
        bq.push_back(e);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        // local flags: the valids read here would still show the pre-edge value
        while ((aw_left || w_left) && t < 64) begin
            @(posedge aclk);
            t++;
            if (aw_left && awready) begin
                awvalid <= 1'b0;
                aw_left = 1'b0;
            end
            if (w_left && wready) begin
                wvalid <= 1'b0;
                w_left = 1'b0;
            end
        end
        do begin @(posedge aclk); t++; end while (!bvalid && t < 64);
        bready <= 1'b0;
        @(posedge aclk);
    endtask

    task automatic rd(input logic [11:0] a, input logic [31:0] d, input logic [1:0] e);
        int t;
        t = 0;
        rq.push_back(d);
        rr.push_back(e);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin @(posedge aclk); t++; end while (!arready && t < 64);
        arvalid <= 1'b0;
        do begin @(posedge aclk); t++; end while (!rvalid && t < 64);
        rready <= 1'b0;
        @(posedge aclk);
    endtask

    function automatic logic [11:0] ba(input logic [7:0] idx, input int i);
        return {2'h0, idx + 8'(i), 2'h0};
    endfunction

    function automatic logic [31:0] st(input slcr_pkg::slcr_link_stat_type s,
                                       input logic [3:0] d, input logic [1:0] n);
        return {6'h0, s.source_target_kind, s.dest, 4'h0, d, 2'h0, n, 1'h0,
                s.junk, s.dst_busy, s.src_busy};
    endfunction

    // responses are matched in issue order; one transfer of each kind at a time
    always @(posedge aclk) begin
        if (bvalid && bready) check(32'(bresp), 32'(bq.pop_front()));
        if (rvalid && rready) begin
            check(rdata, rq.pop_front());
            check(32'(rresp), 32'(rr.pop_front()));
        end
        for (int k = 0; k < 8; k++) begin
            if (link_ctrl[k].greet === 1'b1) greet_n[k]++;
            if (link_ctrl[k].rx_reset === 1'b1) rxrst_n[k]++;
        end
    end

    initial begin
        repeat (20000) @(posedge aclk);
        n_errors++;
        report_and_stop();
    end

    initial begin
        seed = 13;
        repeat (12) @(posedge aclk);
        rstn <= 1'b1;
        @(posedge aclk);
        for (int i = 0; i < 8; i++) begin
            rd(ba(slcr_pkg::IDX_EXT_STAT, i), 32'h0, 2'h0);
            rd(ba(slcr_pkg::IDX_PROC_STAT, i), 32'h0, 2'h0);
            rd(ba(slcr_pkg::IDX_CFG, i), 32'h0, 2'h0);
            rd(ba(slcr_pkg::IDX_STATIC, i), 32'h0, 2'h0);
        end
        load <= 1'b1;
        @(posedge aclk);
        load <= 1'b0;
        @(posedge aclk);
        for (int i = 0; i < 8; i++) begin
            r = $random(seed);
            wr(ba(slcr_pkg::IDX_EXT_STAT, i), r, 2'h0);
            rd(ba(slcr_pkg::IDX_EXT_STAT, i), st(ext_stat[i], r[11:8], r[5:4]), 2'h0);
            check(32'({link_ctrl[i].dir, link_ctrl[i].net}), 32'({r[11:8], r[5:4]}));
            r = $random(seed);
            wr(ba(slcr_pkg::IDX_PROC_STAT, i), r, 2'h0);
            rd(ba(slcr_pkg::IDX_PROC_STAT, i), st(proc_stat[i], 4'h0, r[5:4]), 2'h0);
            check(32'(proc_net[i]), 32'(r[5:4]));
            r = $random(seed) | 32'h0180_0000;
            g = greet_n[i];
            x = rxrst_n[i];
            wr(ba(slcr_pkg::IDX_CFG, i), r, 2'h0);
            // let the far end drop its credit before the read samples it
            repeat (2) @(posedge aclk);
            rd(ba(slcr_pkg::IDX_CFG, i), {r[31:30], 2'h0, ext_flag[i], 3'h0, r[21:0]},
               2'h0);
            check(32'(greet_n[i]), 32'(g + 1));
            check(32'(rxrst_n[i]), 32'(x + 1));
            check(32'({link_ctrl[i].enable, link_ctrl[i].five_wire, link_ctrl[i].sym_gap,
                       link_ctrl[i].tok_gap}), 32'({r[31:30], r[21:0]}));
            r = $random(seed);
            wr(ba(slcr_pkg::IDX_STATIC, i), r, 2'h0);
            rd(ba(slcr_pkg::IDX_STATIC, i), {r[31], 22'h0, r[8], 3'h0, r[4:0]}, 2'h0);
            check(32'(static_fwd[i ^ 2]), 32'({r[31], r[8], r[4:0]}));
        end
        wr(12'h044, '1, 2'h0);
        rd(12'h044, 32'h3, 2'h0);
        wr(12'h444, 32'h0, 2'h2);
        rd(12'h044, 32'h3, 2'h0);
        check(32'(spare), 32'h3);
        // unstrobed lanes keep their value, and bit 24 acts only with lane 3
        wstrb <= 4'he;
        wr(12'h044, 32'h0, 2'h0);
        check(32'(spare), 32'h3);
        g = greet_n[0];
        wstrb <= 4'h7;
        wr(ba(slcr_pkg::IDX_CFG, 0), 32'h0100_0000, 2'h0);
        wstrb <= 4'hf;
        repeat (2) @(posedge aclk);
        check(32'(greet_n[0]), 32'(g));
        check(32'(link_ctrl[0].tok_gap), 32'h0);
        rd(12'h0a0, 32'h0, 2'h2);
        rd(12'h3fc, 32'h0, 2'h2);
        wr(12'h07c, '1, 2'h0);
        rd(12'h07c, 32'h13, 2'h0);
        for (int i = 0; i < 2; i++) begin
            dbg_ev <= 1'b1;
            dbg_core <= 1'(1 - i);
            @(posedge aclk);
            dbg_ev <= 1'b0;
            @(posedge aclk);
            check(32'(dbg_src), 32'h2 >> i);
            rd(12'h07c, 32'h10 | (32'h2 >> i), 2'h0);
        end
        repeat (4) @(posedge aclk);
        // a request left unanswered leaves its note behind
        check(32'(rq.size() + rr.size() + bq.size()), 32'h0);
        report_and_stop();
    end
endmodule
